/* include/rpes_pkg.sv */
// Constants, field layouts and carrier types of the reprogram error signalling block
package rpes_pkg;

    // ****************************************
    // Bus words and subaddresses
    // ****************************************
    localparam int          WORD_W       = 16;
    localparam int          CODE_W       = 14;
    localparam logic [4:0]  SA_ACTIVITY  = 5'h07;
    localparam logic [4:0]  SA_REPORT    = 5'h17;

    // Status report word fields
    localparam int          REP_VALID_BIT = 15;
    localparam int          REP_IND_BIT   = 14;

    // Status report codes
    localparam logic [13:0] CODE_ABORT   = 14'h0001;
    localparam logic [13:0] CODE_RESTART = 14'h0002;
    localparam logic [13:0] CODE_REPEAT  = 14'h0003;
    localparam logic [13:0] CODE_AUTO    = 14'h0004;

    // Activity data word fields
    localparam int          ACT_BUSY_BIT = 15;
    localparam logic [10:0] ACT_REQ_REPORT = {1'b1, 5'h17, 5'h01};

    // Loader error notification bits
    localparam int          NOTE_ABORT_BIT   = 2;
    localparam int          NOTE_RESTART_BIT = 1;
    localparam int          NOTE_REPEAT_BIT  = 0;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STAT   = 4'h1;
    localparam logic [3:0]  REG_CODE   = 4'h2;
    localparam logic [3:0]  REG_NOTE   = 4'h3;
    localparam logic [3:0]  REG_KEY    = 4'h4;
    localparam logic [3:0]  REG_WCOUNT = 4'h5;

    localparam int          CTRL_ENABLE_BIT  = 0;
    localparam int          CTRL_WORDBSY_BIT = 1;
    localparam logic [1:0]  CTRL_RESET       = 2'h0;
    localparam logic [7:0]  KEY_RESET        = 8'h00;
    localparam int          STAT_LOST_BIT    = 3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_HALT, ST_OFFER} rpes_state_t;

    typedef struct packed {
        logic        tr;
        logic [4:0]  subaddr;
        logic [15:0] data;
    } rpes_msg_t;

    typedef struct packed {
        logic        valid;
        logic        indicator;
        logic [13:0] code;
    } rpes_report_t;

endpackage

/* hdl/rpes_core.sv */
// Reprogram error signalling of the unit under reprogramming (terminal side)
//
// Summary of operation
// - Unit halts reprogramming to report an error by raising busy, status or activity word.
// - Activity data word requests transmit, report subaddress, one data word.
// - Report top bit marks validity; loader ignores a report with it clear.
// - Indicator bit: zero means low field is an error code, one means no error.
// - Unit never emits error codes five and above; they are reserved.
// - Receive to subaddress 17h carries the loader error notification word.
// - Unit erases memory itself, driven by the addressed writes it receives.
// - Write cycle count beyond limit gives abort; count masked from verify data.
// - Reprogram control command validated against stored key and enable pin; only an entry command is checked, an exit command always clears the mode.
// - Verify reuses load transactions; unit transmits memory for comparison.
// - Checksum mismatch declares an error and requests the status report.
// - Report is fetched by a transmit command to subaddress 17h.
//
// The address-and-strobe port and the address map were left to the implementer.
module rpes_core
    import rpes_pkg::*;
#(
    parameter int SECTORS     = 8,
    parameter int WRITE_LIMIT = 1000
)(
    // Clock, reset, enable
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        ce,
    // Register port
    input  wire logic [3:0]                  reg_addr,
    input  wire logic [15:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [15:0]                 reg_rdata,
    // Served messages from the terminal core
    input  wire logic                        msg_valid,
    input  wire rpes_msg_t                   msg,
    output logic                             status_busy,
    output logic      [15:0]                 activity_word,
    output rpes_report_t                     report_word,
    // Transaction checksum
    input  wire logic                        txn_start,
    input  wire logic                        sum_word_valid,
    input  wire logic [15:0]                 sum_word,
    input  wire logic                        chk_valid,
    input  wire logic [15:0]                 chk_word,
    // Memory writes and erase
    input  wire logic                        mem_wr_valid,
    input  wire logic [$clog2(SECTORS)-1:0]  mem_wr_sector,
    output logic                             mem_wr_commit,
    output logic                             erase_req,
    output logic      [$clog2(SECTORS)-1:0]  erase_sector,
    input  wire logic                        erase_done,
    input  wire logic                        prog_cycle,
    // Verify data
    input  wire logic                        vfy_valid,
    input  wire logic [15:0]                 vfy_word,
    input  wire logic                        vfy_is_count,
    output logic                             vfy_out_valid,
    output logic      [15:0]                 vfy_out_word,
    // Reprogram control
    input  wire logic                        ctrl_valid,
    input  wire logic [15:0]                 ctrl_word,
    input  wire logic                        enable_pin,
    output logic                             reprog_mode
);

    localparam logic [15:0] LIMIT = 16'(WRITE_LIMIT);

    // ****************************************
    // Declarations
    // ****************************************
    rpes_state_t            state;
    rpes_state_t            next_state;
    logic [1:0]             en_sync;
    logic [1:0]             ctrl_reg;
    logic [7:0]             key_reg;
    logic [2:0]             note;
    logic [15:0]            wcount;
    logic [15:0]            sum_acc;
    logic [SECTORS-1:0]     erased;
    logic                   erase_pend;
    logic                   next_erase_pend;
    logic                   seen_poll;
    logic                   lost;
    logic                   next_busy;
    logic                   poll_ev;
    logic                   read_ev;
    logic                   note_ev;
    logic                   chk_err;
    logic                   limit_err;
    logic                   sw_err;
    logic                   sw_prog;
    logic                   err_ev;
    logic [13:0]            err_code;
    logic                   ctrl_ok;
    logic                   mode_on;
    logic                   wr_code;

    // ****************************************
    // Event decode
    // ****************************************
    assign poll_ev   = msg_valid && msg.tr && msg.subaddr == SA_ACTIVITY;
    assign read_ev   = msg_valid && msg.tr && msg.subaddr == SA_REPORT;
    assign note_ev   = msg_valid && !msg.tr && msg.subaddr == SA_REPORT;
    assign wr_code   = reg_wr && reg_addr == REG_CODE;
    assign chk_err   = reprog_mode && chk_valid && chk_word != sum_acc;
    assign limit_err = prog_cycle && wcount >= LIMIT;
    // Software error codes outside one to four are refused
    assign sw_err    = wr_code && !reg_wdata[REP_IND_BIT]
                       && reg_wdata[13:0] >= CODE_ABORT && reg_wdata[13:0] <= CODE_AUTO;
    assign sw_prog   = wr_code && reg_wdata[REP_IND_BIT];
    assign err_ev    = chk_err || limit_err || sw_err;
    assign ctrl_ok   = en_sync[1] && ctrl_reg[CTRL_ENABLE_BIT]
                       && ctrl_word[15:8] == key_reg;
    assign mode_on   = ctrl_valid && ctrl_word[0] && ctrl_ok && !reprog_mode;

    // Write limit aborts, checksum fault asks an automatic repeat
    always_comb begin
        if (limit_err) begin
            err_code = CODE_ABORT;
        end else if (chk_err) begin
            err_code = CODE_AUTO;
        end else begin
            err_code = reg_wdata[13:0];
        end
    end

    // ****************************************
    // Enable pin synchroniser
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            en_sync <= 2'h0;
        end else if (ce) begin
            en_sync <= {en_sync[0], enable_pin};
        end
    end

    // ****************************************
    // Report sequence
    // ****************************************
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (err_ev) begin
                    next_state = ST_HALT;
                end else if (sw_prog) begin
                    next_state = ST_OFFER;
                end
            end
            ST_HALT: begin
                // Busy must be answered to at least one poll before it clears
                if (seen_poll && !erase_pend) begin
                    next_state = ST_OFFER;
                end
            end
            ST_OFFER: begin
                if (read_ev) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seen_poll <= 1'b0;
        end else if (ce) begin
            seen_poll <= (state == ST_HALT) && next_state == ST_HALT && (seen_poll || poll_ev);
        end
    end

    // Report is loaded only in idle and only its valid bit clears on the read, so it holds while offered
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            report_word <= '0;
        end else if (ce) begin
            if (state == ST_IDLE && err_ev) begin
                report_word <= '{valid: 1'b1, indicator: 1'b0, code: err_code};
            end else if (state == ST_IDLE && sw_prog) begin
                report_word <= '{valid: 1'b1, indicator: 1'b1, code: reg_wdata[13:0]};
            end else if (state == ST_OFFER && read_ev) begin
                report_word.valid <= 1'b0;
            end
        end
    end

    // Errors that arrive while a report is outstanding are dropped but flagged
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lost <= 1'b0;
        end else if (ce) begin
            if (err_ev && state != ST_IDLE) begin
                lost <= 1'b1;
            end else if (reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_LOST_BIT]) begin
                lost <= 1'b0;
            end
        end
    end

    // ****************************************
    // Busy and activity word
    // ****************************************
    assign next_busy = next_state == ST_HALT || next_erase_pend;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_busy   <= 1'b0;
            activity_word <= 16'h0000;
        end else if (ce) begin
            status_busy   <= next_busy && !ctrl_reg[CTRL_WORDBSY_BIT];
            activity_word <= 16'h0000;
            activity_word[ACT_BUSY_BIT] <= next_busy && ctrl_reg[CTRL_WORDBSY_BIT];
            if (next_state == ST_OFFER) begin
                activity_word[10:0] <= ACT_REQ_REPORT;
            end
        end
    end

    // ****************************************
    // Loader error notification
    // ****************************************
    // Upper bits are ignored; a new notification wins over a software clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            note <= 3'h0;
        end else if (ce) begin
            note <= (note & ~((reg_wr && reg_addr == REG_NOTE) ? reg_wdata[2:0] : 3'h0))
                    | (note_ev ? msg.data[2:0] : 3'h0);
        end
    end

    // ****************************************
    // Reprogramming mode
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reprog_mode <= 1'b0;
        end else if (ce) begin
            if (note_ev && msg.data[NOTE_ABORT_BIT]) begin
                reprog_mode <= 1'b0;
            end else if (ctrl_valid && !ctrl_word[0]) begin
                reprog_mode <= 1'b0;
            end else if (mode_on) begin
                reprog_mode <= 1'b1;
            end
        end
    end

    // ****************************************
    // Checksum
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sum_acc <= 16'h0000;
        end else if (ce) begin
            if (txn_start) begin
                sum_acc <= sum_word_valid ? sum_word : 16'h0000;
            end else if (sum_word_valid) begin
                sum_acc <= sum_acc + sum_word;
            end
        end
    end

    // ****************************************
    // Erase ahead of addressed writes
    // ****************************************
    // A write to an unerased sector starts its erase and is dropped; the
    // loader repeats it once busy clears
    assign next_erase_pend = erase_done ? 1'b0 :
                             (erase_pend || (reprog_mode && mem_wr_valid
                                             && !erased[mem_wr_sector]));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            erase_pend    <= 1'b0;
            erase_req     <= 1'b0;
            erase_sector  <= '0;
            mem_wr_commit <= 1'b0;
        end else if (ce) begin
            erase_pend    <= next_erase_pend;
            erase_req     <= !erase_pend && next_erase_pend;
            mem_wr_commit <= reprog_mode && mem_wr_valid && erased[mem_wr_sector];
            if (!erase_pend && next_erase_pend) begin
                erase_sector <= mem_wr_sector;
            end
        end
    end

    for (genvar i = 0; i < SECTORS; i++) begin : g_erased
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                erased[i] <= 1'b0;
            end else if (ce) begin
                if (mode_on) begin
                    erased[i] <= 1'b0;
                end else if (erase_done && erase_pend && erase_sector == i) begin
                    erased[i] <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Write cycle count and verify masking
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wcount <= 16'h0000;
        end else if (ce) begin
            if (prog_cycle && wcount != 16'hffff) begin
                wcount <= wcount + 16'h0001;
            end else if (reg_wr && reg_addr == REG_WCOUNT) begin
                wcount <= reg_wdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vfy_out_valid <= 1'b0;
            vfy_out_word  <= 16'h0000;
        end else if (ce) begin
            vfy_out_valid <= vfy_valid;
            vfy_out_word  <= vfy_is_count ? 16'h0000 : vfy_word;
        end
    end

    // ****************************************
    // Register port
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_reg <= CTRL_RESET;
            key_reg  <= KEY_RESET;
        end else if (ce && reg_wr) begin
            if (reg_addr == REG_CTRL) begin
                ctrl_reg <= reg_wdata[1:0];
            end
            if (reg_addr == REG_KEY) begin
                key_reg <= reg_wdata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_CTRL:   reg_rdata <= {14'h0000, ctrl_reg};
                    REG_STAT:   reg_rdata <= {10'h000, erase_pend, en_sync[1], lost,
                                              state == ST_OFFER, next_busy, reprog_mode};
                    REG_CODE:   reg_rdata <= report_word;
                    REG_NOTE:   reg_rdata <= {13'h0000, note};
                    REG_KEY:    reg_rdata <= {8'h00, key_reg};
                    REG_WCOUNT: reg_rdata <= wcount;
                    default:    reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_error_taken;
        ce && state == ST_IDLE && err_ev;
    endsequence

    sequence s_halt_ends;
        ce && state == ST_HALT && next_state == ST_OFFER;
    endsequence

    halt_on_error_a: assert property (s_error_taken |=> state == ST_HALT
        && (status_busy || activity_word[ACT_BUSY_BIT]))
        else $error("error did not raise busy");
    report_code_a: assert property (s_error_taken |=> report_word.valid
        && !report_word.indicator && report_word.code == $past(err_code))
        else $error("error report not latched");
    offer_request_a: assert property (s_halt_ends |=>
        activity_word[10:0] == ACT_REQ_REPORT && !status_busy)
        else $error("report request missing after busy");
    poll_first_a: assert property (s_halt_ends |-> seen_poll)
        else $error("busy cleared without a busy poll");
    report_stable_a: assert property (state == ST_OFFER && !read_ev |=>
        $stable(report_word))
        else $error("report changed while offered");
    code_range_a: assert property (report_word.valid && !report_word.indicator |->
        report_word.code >= CODE_ABORT && report_word.code <= CODE_AUTO)
        else $error("reserved error code emitted");
    note_set_a: assert property (ce && note_ev |=>
        (note & $past(msg.data[2:0])) == $past(msg.data[2:0]))
        else $error("notification bit lost");
    mode_entry_a: assert property ($rose(reprog_mode) |->
        $past(ctrl_ok) && $past(ctrl_valid))
        else $error("reprogram mode entered without validation");
    verify_mask_a: assert property (ce && vfy_valid && vfy_is_count |=>
        vfy_out_valid && vfy_out_word == 16'h0000)
        else $error("write count leaked into verify data");
    erase_first_a: assert property (ce && reprog_mode && mem_wr_valid
        && !erased[mem_wr_sector] && !erase_pend && !erase_done |=> erase_req && !mem_wr_commit)
        else $error("write to unerased sector committed");
    checksum_fault_a: assert property (ce && state == ST_IDLE && chk_err && !limit_err
        |=> report_word.code == CODE_AUTO ##0 state == ST_HALT)
        else $error("checksum fault not reported");

endmodule

/* bench/rpes_loader.sv */
// Memory loader model acting as bus controller towards the unit
module rpes_loader
    import rpes_pkg::*;
(
    // Clock and unit outputs
    input  wire logic        sys_clk,
    input  wire logic        status_busy,
    input  wire logic [15:0] activity_word,
    // Served messages
    output logic             msg_valid,
    output rpes_msg_t        msg
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        msg_valid = 1'b0;
        msg = '0;
    end
    task automatic send(input logic tr, input logic [4:0] sa, input logic [15:0] d);
        msg_valid <= 1'b1;
        msg <= {tr, sa, d};
        @(posedge sys_clk);
        msg_valid <= 1'b0;
        msg <= ~{tr, sa, d}; // Released bus shows no stale word
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    // Polls while busy, fetches the report once it is requested
    // Never hands over execution control, so unverified memory is never run
    task automatic serve(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 16 && !ok; i++) begin
            send(1'b1, SA_ACTIVITY, 16'h0000);
            ok = !status_busy && activity_word[10:0] === ACT_REQ_REPORT;
        end
        if (ok) begin
            send(1'b1, SA_REPORT, 16'h0000);
        end
    endtask
endmodule

/* bench/tb_reprogram_error_signalling.sv */
// Self-checking bench of the reprogram error signalling core
module tb_reprogram_error_signalling
    import rpes_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, sys_rst, ce, reg_wr, reg_rd, msg_valid, status_busy, txn_start, ok;
    logic sum_word_valid, chk_valid, mem_wr_valid, mem_wr_commit, erase_req, erase_done;
    logic prog_cycle, vfy_valid, vfy_is_count, vfy_out_valid, ctrl_valid, enable_pin;
    logic reprog_mode;
    logic [3:0]   reg_addr;
    logic [2:0]   mem_wr_sector, erase_sector;
    logic [15:0]  reg_wdata, reg_rdata, activity_word, sum_word, chk_word, vfy_word;
    logic [15:0]  vfy_out_word, ctrl_word, seed, a, d;
    rpes_msg_t    msg;
    rpes_report_t report_word;
    int           errors = 0;
    int           n_compared = 0;
    int           cycles = 0;
    rpes_core rpes_core_inst (.*);
    rpes_loader rpes_loader_inst (.*);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] exp_rep(input logic [13:0] c);
        return {2'b10, c};
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [15:0] rv);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    task automatic give_verdict();
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        {sys_rst, ce, enable_pin, seed} = {3'b111, 16'h0043};
        {reg_wr, reg_rd, txn_start, sum_word_valid, chk_valid, mem_wr_valid} = '0;
        {erase_done, prog_cycle, vfy_valid, vfy_is_count, ctrl_valid} = '0;
        {reg_addr, mem_wr_sector, reg_wdata, sum_word, chk_word, vfy_word, ctrl_word} = '0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        check("reset", {report_word[15:1], status_busy | reprog_mode}, 16'h0000);
        seed = lfsr(seed);
        wr(REG_KEY, {8'h00, seed[7:0]});
        rd(REG_KEY, d);
        check("key", d, {8'h00, seed[7:0]});
        rd(4'hf, d);
        check("unmapped", d, 16'h0000);
        wr(REG_CTRL, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            ctrl_word <= {seed[7:0] ^ 8'(1 - k), 8'h01};
            ctrl_valid <= 1'b1;
            @(posedge sys_clk);
            ctrl_valid <= 1'b0;
            @(posedge sys_clk);
            #1;
            check("mode", 16'(reprog_mode), 16'(k));
        end
        for (int c = 1; c < 5; c++) begin
            wr(REG_CODE, 16'(c));
            @(posedge sys_clk);
            #1;
            check("report", report_word, exp_rep(14'(c)));
            check("busy", 16'(status_busy), 16'h0001);
            rpes_loader_inst.serve(ok);
            check("served", 16'(ok), 16'h0001);
            check("cleared", 16'(report_word.valid), 16'h0000);
        end
        wr(REG_CODE, {8'h00, seed[7:0]} | 16'h0005);
        @(posedge sys_clk);
        #1;
        check("reserved", 16'(report_word.valid | status_busy), 16'h0000);
        seed = lfsr(seed);
        wr(REG_CODE, {2'b01, seed[13:0]});
        @(posedge sys_clk);
        #1;
        check("progress", report_word, {2'b11, seed[13:0]});
        check("no busy", 16'(status_busy), 16'h0000);
        rpes_loader_inst.serve(ok);
        check("progress read", 16'(ok), 16'h0001);
        for (int m = 0; m < 2; m++) begin
            seed = lfsr(seed);
            a = lfsr(seed);
            {txn_start, sum_word_valid, sum_word} <= {2'b11, seed};
            @(posedge sys_clk);
            {txn_start, sum_word} <= {1'b0, a};
            @(posedge sys_clk);
            {sum_word_valid, chk_valid, chk_word} <= {2'b01, (seed + a) ^ 16'(m)};
            @(posedge sys_clk);
            chk_valid <= 1'b0;
            @(posedge sys_clk);
            #1;
            check("sum", 16'({report_word.valid, status_busy}), 16'(3 * m));
        end
        check("sum code", report_word, exp_rep(CODE_AUTO));
        rpes_loader_inst.serve(ok);
        check("sum served", 16'(ok), 16'h0001);
        for (int v = 0; v < 2; v++) begin
            seed = lfsr(seed);
            {vfy_word, vfy_is_count, vfy_valid} <= {seed, v[0], 1'b1};
            @(posedge sys_clk);
            vfy_valid <= 1'b0;
            #1;
            check("verify", vfy_out_word, v ? 16'h0000 : seed);
            check("verify valid", 16'(vfy_out_valid), 16'h0001);
        end
        mem_wr_sector <= seed[2:0];
        for (int e = 0; e < 3; e++) begin
            mem_wr_valid <= e != 1;
            erase_done <= e == 1;
            @(posedge sys_clk);
            {mem_wr_valid, erase_done} <= 2'b00;
            #1;
            d = 16'({erase_req, erase_sector, status_busy, mem_wr_commit});
            check("erase", d, 16'({e == 0, seed[2:0], e == 0, e == 2}));
        end
        wr(REG_CTRL, 16'h0003);
        @(posedge sys_clk);
        wr(REG_WCOUNT, 16'(rpes_core_inst.WRITE_LIMIT - 1));
        for (int p = 0; p < 2; p++) begin
            prog_cycle <= 1'b1;
            @(posedge sys_clk);
            prog_cycle <= 1'b0;
            @(posedge sys_clk);
            #1;
            d = 16'({activity_word[ACT_BUSY_BIT], status_busy, report_word.valid});
            check("limit", d, 16'(5 * p));
        end
        check("abort code", report_word, exp_rep(CODE_ABORT));
        rd(REG_WCOUNT, d);
        check("count", d, 16'(rpes_core_inst.WRITE_LIMIT + 1));
        rpes_loader_inst.serve(ok);
        check("word served", 16'({ok, activity_word[ACT_BUSY_BIT]}), 16'h0002);
        rpes_loader_inst.send(1'b1, SA_ACTIVITY, 16'h0000);
        check("poll busy", 16'(activity_word[ACT_BUSY_BIT]), 16'h0000);
        rpes_loader_inst.send(1'b0, SA_REPORT, 16'h0007);
        rd(REG_NOTE, d);
        check("note", d, 16'h0007);
        check("left", 16'(reprog_mode), 16'h0000);
        give_verdict();
    end
endmodule
